// ==== src/fbus_msg_pkg.sv ====
// Purpose: Shared constants for the fieldbus process image and message area.
// Assumes: Byte offsets are positions in the cyclic process image.
// Notes:   Message fields keep one relative layout in both maps.
package fbus_msg_pkg;
    localparam int unsigned MAX_WORDS      = 4;
    // Compact map positions
    localparam logic [4:0]  CMP_CMD_HI     = 5'h00;
    localparam logic [4:0]  CMP_CMD_LO     = 5'h01;
    localparam logic [4:0]  CMP_REF_HI     = 5'h02;
    localparam logic [4:0]  CMP_REF_LO     = 5'h03;
    localparam logic [4:0]  CMP_MSG_BASE   = 5'h04;
    localparam logic [4:0]  CMP_MSG_LAST   = 5'h09;
    localparam logic [4:0]  CMP_HS         = 5'h0B;
    // Full map positions
    localparam logic [4:0]  FUL_MSG_BASE   = 5'h10;
    localparam logic [4:0]  FUL_MSG_LAST   = 5'h1B;
    localparam logic [4:0]  FUL_HS         = 5'h1F;
    // Offsets inside the message area
    localparam logic [4:0]  MSG_FUNC       = 5'h00;
    localparam logic [4:0]  MSG_ADDR_HI    = 5'h01;
    localparam logic [4:0]  MSG_ADDR_LO    = 5'h02;
    localparam logic [4:0]  MSG_CNT        = 5'h03;
    localparam logic [4:0]  MSG_DATA       = 5'h04;
    localparam int unsigned HS_BIT         = 7;
    // Function and response codes
    localparam logic [7:0]  FC_READ        = 8'h03;
    localparam logic [7:0]  FC_LOOP        = 8'h08;
    localparam logic [7:0]  FC_WRITE       = 8'h10;
    localparam logic [7:0]  RESP_WAIT      = 8'h00;
    localparam logic [7:0]  RESP_ERR_FLAG  = 8'h80;
    localparam logic [7:0]  ERR_CNT        = 8'h02;
    localparam logic [7:0]  ERR_BAD_FUNC   = 8'h01;
    localparam logic [7:0]  ERR_BAD_LEN    = 8'h21;
    localparam logic [7:0]  CMP_MAX_BYTES  = 8'h02;
    localparam logic [7:0]  FUL_MAX_BYTES  = 8'h08;
    // Software register map
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h1;
    localparam logic [3:0]  REG_IRQ_STAT   = 4'h2;
    localparam logic [3:0]  REG_IRQ_MASK   = 4'h3;
    localparam logic [3:0]  REG_DRV_STAT   = 4'h4;
    localparam int unsigned CTRL_FULL_MAP  = 0;
    localparam int unsigned CTRL_FREQ_SPD  = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h0;
    localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;
    localparam int unsigned IRQ_RESP       = 0;
    localparam int unsigned IRQ_ERR        = 1;
    localparam int unsigned IRQ_FAULT      = 2;
    localparam int unsigned STAT_FAULT     = 7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } eng_state_t;
endpackage

// ==== src/msg_if.sv ====
// Purpose: Carries the message area between the image logic and the engine.
// Assumes: One clock domain.
// Notes:   host side owns the master's request, engine side owns the response.
`timescale 1ns/1ps
`default_nettype none
interface msg_if;
    logic                                          compact;
    logic                                          hs_out;
    logic [7:0]                                    func;
    logic [15:0]                                   addr;
    logic [7:0]                                    cnt;
    logic [fbus_msg_pkg::MAX_WORDS-1:0][15:0]      wdata;
    logic                                          hs_in;
    logic [7:0]                                    rfunc;
    logic [15:0]                                   raddr;
    logic [7:0]                                    rcnt;
    logic [fbus_msg_pkg::MAX_WORDS-1:0][15:0]      rdata;
    logic                                          busy;
    logic                                          ev_resp;
    logic                                          ev_err;
    modport host (output compact, hs_out, func, addr, cnt, wdata,
                  input hs_in, rfunc, raddr, rcnt, rdata, busy, ev_resp, ev_err);
    modport engine (input compact, hs_out, func, addr, cnt, wdata,
                    output hs_in, rfunc, raddr, rcnt, rdata, busy, ev_resp, ev_err);
endinterface
`default_nettype wire

// ==== src/msg_engine.sv ====
// Purpose: Takes a message on a handshake toggle, checks it, forwards it to the drive.
// Assumes: Drive answers each request with one done pulse, same clock.
// Notes:   A toggle seen while busy is served once the current message ends.
`timescale 1ns/1ps
`default_nettype none
module msg_engine (
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    msg_if.engine      m,
    output logic       o_drv_req,
    output logic [7:0] o_drv_func,
    output logic [15:0] o_drv_addr,
    output logic [7:0] o_drv_cnt,
    output logic [63:0] o_drv_wdata,
    input  wire logic  i_drv_done,
    input  wire logic  i_drv_err,
    input  wire logic [7:0] i_drv_errcode,
    input  wire logic [63:0] i_drv_rdata
);
    typedef struct packed {
        fbus_msg_pkg::eng_state_t                 state;
        logic                                     taken;
        logic                                     hs_in;
        logic [7:0]                               rfunc;
        logic [15:0]                              raddr;
        logic [7:0]                               rcnt;
        logic [fbus_msg_pkg::MAX_WORDS-1:0][15:0] rdata;
        logic                                     req;
        logic [7:0]                               func;
        logic [15:0]                              addr;
        logic [7:0]                               cnt;
        logic [63:0]                              wdata;
        logic                                     ev_resp;
        logic                                     ev_err;
    } eng_t;

    eng_t q;
    eng_t d;

    always_comb
    begin
        logic [7:0] max_bytes;
        logic       len_ok;
        logic       func_ok;
        max_bytes = m.compact ? fbus_msg_pkg::CMP_MAX_BYTES : fbus_msg_pkg::FUL_MAX_BYTES;
        len_ok    = (m.cnt != 8'h00) && !m.cnt[0] && (m.cnt <= max_bytes);
        func_ok   = (m.func == fbus_msg_pkg::FC_READ) || (m.func == fbus_msg_pkg::FC_LOOP)
                    || (m.func == fbus_msg_pkg::FC_WRITE);
        d         = q;
        d.req     = 1'b0;
        d.ev_resp = 1'b0;
        d.ev_err  = 1'b0;
        case (q.state)
            fbus_msg_pkg::ST_IDLE:
            begin
                if (m.hs_out != q.taken)
                begin
                    d.taken = m.hs_out;
                    d.raddr = m.addr;
                    d.rdata = '0;
                    d.func  = m.func;
                    if (!func_ok || !len_ok)
                    begin
                        // Refused locally, the drive never sees it
                        d.rfunc    = m.func | fbus_msg_pkg::RESP_ERR_FLAG;
                        d.rcnt     = fbus_msg_pkg::ERR_CNT;
                        d.rdata[0] = {8'h00, func_ok ? fbus_msg_pkg::ERR_BAD_LEN : fbus_msg_pkg::ERR_BAD_FUNC};
                        d.hs_in    = m.hs_out;
                        d.ev_resp  = 1'b1;
                        d.ev_err   = 1'b1;
                    end
                    else
                    begin
                        d.rfunc = fbus_msg_pkg::RESP_WAIT;
                        d.rcnt  = m.cnt;
                        d.req   = 1'b1;
                        d.addr  = m.addr;
                        d.cnt   = m.cnt;
                        d.wdata = (m.func == fbus_msg_pkg::FC_READ) ? 64'h0 : m.wdata;
                        d.state = fbus_msg_pkg::ST_WAIT;
                    end
                end
            end
            fbus_msg_pkg::ST_WAIT:
            begin
                if (i_drv_done)
                begin
                    if (i_drv_err)
                    begin
                        d.rfunc    = q.func | fbus_msg_pkg::RESP_ERR_FLAG;
                        d.rcnt     = fbus_msg_pkg::ERR_CNT;
                        d.rdata[0] = {8'h00, i_drv_errcode};
                        d.ev_err   = 1'b1;
                    end
                    else
                    begin
                        d.rfunc = q.func;
                        for (int i = 0; i < fbus_msg_pkg::MAX_WORDS; i++)
                        begin
                            // Only words inside the byte count carry data back
                            if ((q.func != fbus_msg_pkg::FC_WRITE) && (8'(2 * i) < q.cnt))
                                d.rdata[i] = i_drv_rdata[16*i +: 16];
                        end
                    end
                    d.hs_in   = q.taken;
                    d.ev_resp = 1'b1;
                    d.state   = fbus_msg_pkg::ST_IDLE;
                end
            end
            default:
            begin
                d.state = fbus_msg_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            q       <= '0;
            q.state <= fbus_msg_pkg::ST_IDLE;
            q.rfunc <= fbus_msg_pkg::RESP_WAIT;
        end
        else
        begin
            q <= d;
        end
    end

    assign m.hs_in      = q.hs_in;
    assign m.rfunc      = q.rfunc;
    assign m.raddr      = q.raddr;
    assign m.rcnt       = q.rcnt;
    assign m.rdata      = q.rdata;
    assign m.busy       = (q.state == fbus_msg_pkg::ST_WAIT);
    assign m.ev_resp    = q.ev_resp;
    assign m.ev_err     = q.ev_err;
    assign o_drv_req    = q.req;
    assign o_drv_func   = q.func;
    assign o_drv_addr   = q.addr;
    assign o_drv_cnt    = q.cnt;
    assign o_drv_wdata  = q.wdata;
endmodule
`default_nettype wire

// ==== src/fbus_drive_msg_area.sv ====
// Purpose: Cyclic process image of a drive fieldbus card with its message area.
// Assumes: Image port and drive link are on I_CLK_SYS; drive status bits are pins.
// Notes:   Full map bytes 0..15 are served elsewhere and read here as zero.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Status bits 0-7 report run through fault
// - Status bits 8-F report error through servo
// - Device returns status, speed high byte first
// - V/f or open-loop PM sends frequency
// - Message fields at bytes 4 to 9
// - Byte 10 reserved, byte 11 handshake
// - Message forwarded to drive, answer later
// - At most four data words per message
// - Function codes 03H, 08H, 10H only
// - Count in bytes: 2, 4, 6, 8
// - Handshake bit 7 toggle starts, match answers
// - Response 00H waiting, code, or error
// - Error: MSB set, count 02H, code
module fbus_drive_msg_area #(
    parameter int unsigned DATA_WORDS = fbus_msg_pkg::MAX_WORDS
) (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_SYS_RST,
    input  wire logic [3:0]  I_ADDR,
    input  wire logic [15:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [15:0] O_RDATA,
    output logic             O_IRQ,
    input  wire logic        I_PD_WR,
    input  wire logic        I_PD_RD,
    input  wire logic [4:0]  I_PD_ADDR,
    input  wire logic [7:0]  I_PD_WDATA,
    output logic      [7:0]  O_PD_RDATA,
    output logic      [15:0] O_OP_CMD,
    output logic      [15:0] O_FREQ_REF,
    input  wire logic [15:0] I_DRIVE_STATUS,
    input  wire logic [15:0] I_MOTOR_SPEED,
    input  wire logic [15:0] I_OUT_FREQ,
    output logic             O_DRV_REQ,
    output logic      [7:0]  O_DRV_FUNC,
    output logic      [15:0] O_DRV_ADDR,
    output logic      [7:0]  O_DRV_CNT,
    output logic      [63:0] O_DRV_WDATA,
    input  wire logic        I_DRV_DONE,
    input  wire logic        I_DRV_ERR,
    input  wire logic [7:0]  I_DRV_ERRCODE,
    input  wire logic [63:0] I_DRV_RDATA
);
    if (DATA_WORDS != fbus_msg_pkg::MAX_WORDS)
    begin : g_check
        $error("DATA_WORDS must equal the message area word count");
    end

    typedef struct packed {
        logic [15:0]                              sync1;
        logic [15:0]                              sync2;
        logic                                     fault_prev;
        logic [1:0]                               ctrl;
        logic [2:0]                               irq_stat;
        logic [2:0]                               irq_mask;
        logic                                     irq;
        logic [15:0]                              rdata;
        logic [7:0]                               pd_rdata;
        logic [15:0]                              op_cmd;
        logic [15:0]                              freq_ref;
        logic [7:0]                               func;
        logic [15:0]                              addr;
        logic [7:0]                               cnt;
        logic [fbus_msg_pkg::MAX_WORDS-1:0][15:0] wdata;
        logic                                     hs_out;
    } top_t;

    top_t q;
    top_t d;
    msg_if m ();

    // Response byte at a message-relative offset
    function automatic logic [7:0] resp_byte(input logic [4:0] rel);
        logic [4:0] widx;
        widx = (rel - fbus_msg_pkg::MSG_DATA) >> 1;
        if (rel == fbus_msg_pkg::MSG_FUNC)
            return m.rfunc;
        else if (rel == fbus_msg_pkg::MSG_ADDR_HI)
            return m.raddr[15:8];
        else if (rel == fbus_msg_pkg::MSG_ADDR_LO)
            return m.raddr[7:0];
        else if (rel == fbus_msg_pkg::MSG_CNT)
            return m.rcnt;
        else if (rel[0] == fbus_msg_pkg::MSG_DATA[0])
            return m.rdata[widx[1:0]][15:8];
        else
            return m.rdata[widx[1:0]][7:0];
    endfunction

    always_comb
    begin
        logic       full;
        logic [4:0] rel;
        logic [4:0] widx;
        logic       in_msg;
        logic       at_hs;
        logic [15:0] speed;
        logic [7:0] img;
        logic [15:0] reg_rd;
        logic [2:0] events;
        logic [2:0] clr;
        reg_rd = 16'h0000;
        full   = q.ctrl[fbus_msg_pkg::CTRL_FULL_MAP];
        rel    = I_PD_ADDR - (full ? fbus_msg_pkg::FUL_MSG_BASE : fbus_msg_pkg::CMP_MSG_BASE);
        widx   = (rel - fbus_msg_pkg::MSG_DATA) >> 1;
        in_msg = full ? (I_PD_ADDR >= fbus_msg_pkg::FUL_MSG_BASE && I_PD_ADDR <= fbus_msg_pkg::FUL_MSG_LAST)
                      : (I_PD_ADDR >= fbus_msg_pkg::CMP_MSG_BASE && I_PD_ADDR <= fbus_msg_pkg::CMP_MSG_LAST);
        at_hs  = I_PD_ADDR == (full ? fbus_msg_pkg::FUL_HS : fbus_msg_pkg::CMP_HS);
        // Frequency stands in for speed when no speed is measured
        speed  = q.ctrl[fbus_msg_pkg::CTRL_FREQ_SPD] ? I_OUT_FREQ : I_MOTOR_SPEED;
        d      = q;
        // Pins pass two flops; the first is read only by the second
        d.sync1 = I_DRIVE_STATUS;
        d.sync2 = q.sync1;
        d.fault_prev = q.sync2[fbus_msg_pkg::STAT_FAULT];

        // Master image writes; reserved and unmapped bytes are dropped
        if (I_PD_WR)
        begin
            if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_CMD_HI)
                d.op_cmd[15:8] = I_PD_WDATA;
            else if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_CMD_LO)
                d.op_cmd[7:0] = I_PD_WDATA;
            else if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_REF_HI)
                d.freq_ref[15:8] = I_PD_WDATA;
            else if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_REF_LO)
                d.freq_ref[7:0] = I_PD_WDATA;
            else if (at_hs)
                d.hs_out = I_PD_WDATA[fbus_msg_pkg::HS_BIT];
            else if (in_msg)
            begin
                if (rel == fbus_msg_pkg::MSG_FUNC)
                    d.func = I_PD_WDATA;
                else if (rel == fbus_msg_pkg::MSG_ADDR_HI)
                    d.addr[15:8] = I_PD_WDATA;
                else if (rel == fbus_msg_pkg::MSG_ADDR_LO)
                    d.addr[7:0] = I_PD_WDATA;
                else if (rel == fbus_msg_pkg::MSG_CNT)
                    d.cnt = I_PD_WDATA;
                else if (rel[0] == fbus_msg_pkg::MSG_DATA[0])
                    d.wdata[widx[1:0]][15:8] = I_PD_WDATA;
                else
                    d.wdata[widx[1:0]][7:0] = I_PD_WDATA;
            end
        end

        // Input image toward the master
        img = 8'h00;
        if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_CMD_HI)
            img = q.sync2[15:8];
        else if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_CMD_LO)
            img = q.sync2[7:0];
        else if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_REF_HI)
            img = speed[15:8];
        else if (!full && I_PD_ADDR == fbus_msg_pkg::CMP_REF_LO)
            img = speed[7:0];
        else if (at_hs)
            img = {m.hs_in, 7'h00};
        else if (in_msg)
            img = resp_byte(rel);
        d.pd_rdata = I_PD_RD ? img : 8'h00;

        // Software registers
        case (I_ADDR)
            fbus_msg_pkg::REG_CTRL:     reg_rd = {14'h0000, q.ctrl};
            fbus_msg_pkg::REG_STATUS:   reg_rd = {5'h00, m.busy, m.hs_in, q.hs_out, m.rfunc};
            fbus_msg_pkg::REG_IRQ_STAT: reg_rd = {13'h0000, q.irq_stat};
            fbus_msg_pkg::REG_IRQ_MASK: reg_rd = {13'h0000, q.irq_mask};
            fbus_msg_pkg::REG_DRV_STAT: reg_rd = q.sync2;
            default:                    reg_rd = 16'h0000;
        endcase
        d.rdata = I_RD ? reg_rd : 16'h0000;
        if (I_WR && I_ADDR == fbus_msg_pkg::REG_CTRL)
            d.ctrl = I_WDATA[1:0];
        if (I_WR && I_ADDR == fbus_msg_pkg::REG_IRQ_MASK)
            d.irq_mask = I_WDATA[2:0];
        clr = (I_WR && I_ADDR == fbus_msg_pkg::REG_IRQ_STAT) ? I_WDATA[2:0] : 3'h0;
        events = '0;
        events[fbus_msg_pkg::IRQ_RESP]  = m.ev_resp;
        events[fbus_msg_pkg::IRQ_ERR]   = m.ev_err;
        events[fbus_msg_pkg::IRQ_FAULT] = q.sync2[fbus_msg_pkg::STAT_FAULT] && !q.fault_prev;
        // A new event beats a clear in the same cycle
        d.irq_stat = (q.irq_stat & ~clr) | events;
        d.irq      = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SYS_RST)
        begin
            q          <= '0;
            q.ctrl     <= fbus_msg_pkg::CTRL_RESET;
            q.irq_mask <= fbus_msg_pkg::IRQ_MASK_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign m.compact = !q.ctrl[fbus_msg_pkg::CTRL_FULL_MAP];
    assign m.hs_out  = q.hs_out;
    assign m.func    = q.func;
    assign m.addr    = q.addr;
    assign m.cnt     = q.cnt;
    assign m.wdata   = q.wdata;

    msg_engine u_engine (
        .i_clk         (I_CLK_SYS),
        .i_rst         (I_SYS_RST),
        .m             (m.engine),
        .o_drv_req     (O_DRV_REQ),
        .o_drv_func    (O_DRV_FUNC),
        .o_drv_addr    (O_DRV_ADDR),
        .o_drv_cnt     (O_DRV_CNT),
        .o_drv_wdata   (O_DRV_WDATA),
        .i_drv_done    (I_DRV_DONE),
        .i_drv_err     (I_DRV_ERR),
        .i_drv_errcode (I_DRV_ERRCODE),
        .i_drv_rdata   (I_DRV_RDATA)
    );

    assign O_RDATA    = q.rdata;
    assign O_IRQ      = q.irq;
    assign O_PD_RDATA = q.pd_rdata;
    assign O_OP_CMD   = q.op_cmd;
    assign O_FREQ_REF = q.freq_ref;
endmodule
`default_nettype wire

// ==== bench/fbus_drive_msg_area_monitor.sv ====
// Purpose: Port-level checks of the fieldbus message area.
// Assumes: One clock, synchronous active high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module fbus_drive_msg_area_monitor (
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_SYS_RST,
    input  wire logic       I_PD_RD,
    input  wire logic [4:0] I_PD_ADDR,
    input  wire logic [7:0] O_PD_RDATA,
    input  wire logic       O_IRQ,
    input  wire logic       O_DRV_REQ,
    input  wire logic [7:0] O_DRV_FUNC,
    input  wire logic [7:0] O_DRV_CNT
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    chk_resv_byte: assert property ($past(I_PD_RD && I_PD_ADDR == 5'h0A) |-> O_PD_RDATA == 8'h00)
        else $error("reserved byte 10 not zero");
    chk_full_resv: assert property ($past(I_PD_RD && I_PD_ADDR inside {5'h1C, 5'h1D, 5'h1E}) |-> !O_PD_RDATA)
        else $error("reserved bytes 28 to 30 not zero");
    chk_hs_low: assert property ($past(I_PD_RD && I_PD_ADDR inside {5'h0B, 5'h1F}) |-> O_PD_RDATA[6:0] == 7'h00)
        else $error("handshake low bits not zero");
    chk_req_pulse: assert property (O_DRV_REQ |=> !O_DRV_REQ)
        else $error("drive request longer than one cycle");
    chk_req_func: assert property (O_DRV_REQ |-> O_DRV_FUNC inside {8'h03, 8'h08, 8'h10})
        else $error("unsupported function forwarded");
    chk_req_cnt: assert property (O_DRV_REQ |-> O_DRV_CNT inside {8'h02, 8'h04, 8'h06, 8'h08})
        else $error("invalid count forwarded");
    chk_req_hold: assert property (O_DRV_REQ |=> $stable(O_DRV_FUNC) && $stable(O_DRV_CNT))
        else $error("forwarded fields moved after request");
    chk_resp_wait: assert property (O_DRV_REQ ##[1:2] (I_PD_RD && I_PD_ADDR inside {5'h04, 5'h10})
        |=> O_PD_RDATA == 8'h00) else $error("response code not waiting");
    cover property (O_DRV_REQ);
    cover property (O_IRQ);
    cover property ($past(I_PD_RD && I_PD_ADDR == 5'h0B) && O_PD_RDATA[7]);
endmodule
bind fbus_drive_msg_area fbus_drive_msg_area_monitor u_mon (.I_CLK_SYS, .I_SYS_RST, .I_PD_RD, .I_PD_ADDR,
    .O_PD_RDATA, .O_IRQ, .O_DRV_REQ, .O_DRV_FUNC, .O_DRV_CNT);
`default_nettype wire

// ==== bench/drive_link_model.sv ====
// Purpose: Drive-side responder for forwarded messages.
// Assumes: One answer per request, i_delay plus two cycles after it.
// Notes:   Read data toggles outside the done pulse so stale use shows.
`timescale 1ns/1ps
`default_nettype none
module drive_link_model (
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_delay,
    input  wire logic        i_fail,
    output logic             o_done,
    output logic             o_err,
    output logic [7:0]       o_errcode,
    output logic [63:0]      o_rdata
);
    int          left = -1;
    logic [15:0] a = 16'h0000;
    // Error code value is arbitrary
    assign o_errcode = 8'h42;
    initial
    begin
        o_done = 1'b0;
        o_err = 1'b0;
        o_rdata = 64'h0;
    end
    always @(posedge i_clk)
    begin
        o_done <= left == 0;
        o_err <= left == 0 && i_fail;
        o_rdata <= left == 0 ? {a + 16'h3, a + 16'h2, a + 16'h1, a} : ~o_rdata;
        if (i_req)
        begin
            left <= int'(i_delay);
            a <= i_addr;
        end
        else if (left >= 0)
            left <= left - 1;
    end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the fieldbus message area.
// Assumes: Drive link answered by the responder model.
// Notes:   Responses are polled on the function code byte.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        I_CLK_SYS = 1'b0, I_SYS_RST = 1'b1, I_WR = 1'b0, I_RD = 1'b0, I_PD_WR = 1'b0, I_PD_RD = 1'b0;
    logic [3:0]  I_ADDR = 4'h0;
    logic [4:0]  I_PD_ADDR = 5'h00;
    logic [7:0]  I_PD_WDATA = 8'h00, O_PD_RDATA, O_DRV_FUNC, O_DRV_CNT, I_DRV_ERRCODE, dly = 8'h05;
    logic [15:0] I_WDATA = 16'h0, I_DRIVE_STATUS = 16'h0, I_MOTOR_SPEED = 16'h1234, I_OUT_FREQ = 16'h0BB8;
    logic [15:0] O_RDATA, O_OP_CMD, O_FREQ_REF, O_DRV_ADDR;
    logic [63:0] O_DRV_WDATA, I_DRV_RDATA;
    logic        O_IRQ, O_DRV_REQ, I_DRV_DONE, I_DRV_ERR, fail = 1'b0, hs = 1'b0;
    int          reqs = 0, error_cnt = 0, check_count = 0;
    fbus_drive_msg_area uut (.I_CLK_SYS, .I_SYS_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_IRQ, .I_PD_WR,
        .I_PD_RD, .I_PD_ADDR, .I_PD_WDATA, .O_PD_RDATA, .O_OP_CMD, .O_FREQ_REF, .I_DRIVE_STATUS, .I_MOTOR_SPEED,
        .I_OUT_FREQ, .O_DRV_REQ, .O_DRV_FUNC, .O_DRV_ADDR, .O_DRV_CNT, .O_DRV_WDATA, .I_DRV_DONE, .I_DRV_ERR,
        .I_DRV_ERRCODE, .I_DRV_RDATA);
    drive_link_model u_drv (.i_clk(I_CLK_SYS), .i_req(O_DRV_REQ), .i_addr(O_DRV_ADDR), .i_delay(dly),
        .i_fail(fail), .o_done(I_DRV_DONE), .o_err(I_DRV_ERR), .o_errcode(I_DRV_ERRCODE), .o_rdata(I_DRV_RDATA));
    always #25 I_CLK_SYS = ~I_CLK_SYS;
    always @(posedge I_CLK_SYS) if (O_DRV_REQ === 1'b1) reqs <= reqs + 1;
    task automatic results;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One strobe cycle; data read after the next edge
    task automatic reg_io(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge I_CLK_SYS);
        {I_WR, I_RD, I_ADDR, I_WDATA} <= {wr, !wr, a, d};
        @(posedge I_CLK_SYS);
        {I_WR, I_RD} <= 2'b00;
        #1;
    endtask
    task automatic pd_io(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge I_CLK_SYS);
        {I_PD_WR, I_PD_RD, I_PD_ADDR, I_PD_WDATA} <= {wr, !wr, a, d};
        @(posedge I_CLK_SYS);
        {I_PD_WR, I_PD_RD} <= 2'b00;
        #1;
    endtask
    task automatic xfer(input logic [4:0] b, input logic [7:0] f, c, input logic [15:0] w, input int n,
                        input logic [7:0] rf, rc, input logic [15:0] rw);
        int r, i;
        logic [4:0] h;
        r = reqs;
        h = (b == 5'h04) ? 5'h0B : 5'h1F;
        pd_io(1, b, f);
        pd_io(1, b + 5'h1, 8'h02);
        pd_io(1, b + 5'h2, 8'h80);
        pd_io(1, b + 5'h3, c);
        pd_io(1, b + 5'h4, w[15:8]);
        pd_io(1, b + 5'h5, w[7:0]);
        hs = !hs;
        pd_io(1, h, {hs, 7'h00});
        for (i = 0; i < 40 && O_PD_RDATA === 8'h00; i++) pd_io(0, b, 8'h00);
        if (i == 40)
        begin
            error_cnt++;
            results;
        end
        chk(O_PD_RDATA, rf);
        pd_io(0, b + 5'h3, 8'h00);
        chk(O_PD_RDATA, rc);
        pd_io(0, b + 5'h4, 8'h00);
        chk(O_PD_RDATA, rw[15:8]);
        pd_io(0, b + 5'h5, 8'h00);
        chk(O_PD_RDATA, rw[7:0]);
        pd_io(0, h, 8'h00);
        chk(O_PD_RDATA, {hs, 7'h00});
        chk(reqs - r, n);
    endtask
    task automatic t_cyclic;
        reg_io(0, 4'h0, 16'h0);
        chk(O_RDATA, 16'h0000);
        reg_io(0, 4'hF, 16'h0);
        chk(O_RDATA, 16'h0000);
        pd_io(1, 5'h00, 8'hA5);
        pd_io(1, 5'h01, 8'h01);
        pd_io(1, 5'h02, 8'h0B);
        pd_io(1, 5'h03, 8'hB8);
        pd_io(1, 5'h0A, 8'hFF);
        chk({O_OP_CMD, O_FREQ_REF}, 32'hA5010BB8);
        pd_io(0, 5'h0A, 8'h00);
        chk(O_PD_RDATA, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge I_CLK_SYS);
            I_DRIVE_STATUS <= 16'h0001 << i;
            repeat (3) @(posedge I_CLK_SYS);
            reg_io(0, 4'h4, 16'h0);
            chk(O_RDATA, 16'h0001 << i);
        end
        for (int i = 0; i < 4; i++)
        begin
            pd_io(0, 5'(i), 8'h00);
            chk(O_PD_RDATA, i < 2 ? 8'(32'h8000 >> (8 - 8 * i)) : 8'(32'h1234 >> (24 - 8 * i)));
        end
        reg_io(1, 4'h0, 16'h0002);
        pd_io(0, 5'h02, 8'h00);
        chk(O_PD_RDATA, 8'h0B);
    endtask
    task automatic t_irq;
        xfer(5'h04, 8'h05, 8'h02, 16'h0, 0, 8'h85, 8'h02, 16'h0001);
        chk(O_IRQ, 1'b0);
        reg_io(0, 4'h2, 16'h0);
        chk(O_RDATA, 16'h0007);
        reg_io(1, 4'h3, 16'h0002);
        repeat (2) @(posedge I_CLK_SYS);
        chk(O_IRQ, 1'b1);
        reg_io(1, 4'h2, 16'h0002);
        repeat (2) @(posedge I_CLK_SYS);
        chk(O_IRQ, 1'b0);
        reg_io(0, 4'h2, 16'h0);
        chk(O_RDATA, 16'h0005);
    endtask
    task automatic t_msgs;
        xfer(5'h04, 8'h03, 8'h02, 16'h0, 1, 8'h03, 8'h02, 16'h0280);
        chk(O_DRV_WDATA, 64'h0);
        xfer(5'h04, 8'h10, 8'h02, 16'h1770, 1, 8'h10, 8'h02, 16'h0);
        chk(O_DRV_WDATA[15:0], 16'h1770);
        xfer(5'h04, 8'h10, 8'h02, 16'h0, 1, 8'h10, 8'h02, 16'h0);
        xfer(5'h04, 8'h08, 8'h02, 16'h1234, 1, 8'h08, 8'h02, 16'h0280);
        xfer(5'h04, 8'h03, 8'h04, 16'h0, 0, 8'h83, 8'h02, 16'h0021);
        reg_io(1, 4'h0, 16'h0001);
        dly <= 8'h00;
        xfer(5'h10, 8'h03, 8'h08, 16'h0, 1, 8'h03, 8'h08, 16'h0280);
        pd_io(0, 5'h1A, 8'h00);
        chk(O_PD_RDATA, 8'h02);
        pd_io(0, 5'h1C, 8'h00);
        chk(O_PD_RDATA, 8'h00);
        fail <= 1'b1;
        xfer(5'h10, 8'h10, 8'h02, 16'h0001, 1, 8'h90, 8'h02, 16'h0042);
        xfer(5'h10, 8'h03, 8'h03, 16'h0, 0, 8'h83, 8'h02, 16'h0021);
    endtask
    initial
    begin
        repeat (3) @(posedge I_CLK_SYS);
        I_SYS_RST <= 1'b0;
        t_cyclic;
        t_irq;
        t_msgs;
        results;
    end
endmodule
`default_nettype wire
